/* File: bench/primary_audio_port_transmit_cfg_bench.sv */
`timescale 1ns/10ps
module primary_audio_port_transmit_cfg_bench
  import psp_pkg::*;
;
  logic mclk, srst, reg_wr, ctrl_mode, hb, hf, va, oa, vb, ob, keep, bc, bco, fs, fso;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, ch_en;
  logic [NCH-1:0][WORD_W-1:0] ch_data;
  logic [NCH-1:0][4:0] ch_slot;
  logic [63:0] cap_a, cap_b;
  int err_total, checked;
  localparam logic [31:0] WORD = 32'hA5C3_96F1;
  wire pin_a = oa ? 1'bz : va;
  wire pin_b = ob ? 1'bz : vb;

  // Clock and watchdog
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  initial begin
    #900_000;
    err_total++;
    wrap_up();
  end

  psp_tx_port i_dut (.mclk_in(mclk), .srst_in(srst), .reg_addr_in(reg_addr),
    .reg_wr_in(reg_wr), .reg_wdata_in(reg_wdata), .reg_rdata_out(reg_rdata),
    .ctrl_mode_in(ctrl_mode), .ext_bclk_in(hb), .ext_fsync_in(hf), .bclk_out(bc),
    .bclk_oe_n_out(bco), .fsync_out(fs), .fsync_oe_n_out(fso), .ch_data_in(ch_data),
    .ch_slot_in(ch_slot), .ch_en_in(ch_en), .serial_out_first_pin_out(va),
    .serial_out_first_pin_oe_n_out(oa), .serial_out_second_pin_out(vb),
    .serial_out_second_pin_oe_n_out(ob), .keeper_en_out(keep));
  psp_host_model #(.HALF(8)) i_host (.mclk_in(mclk), .pin_a_in(pin_a), .pin_b_in(pin_b),
    .bclk_out(hb), .fsync_out(hf), .cap_a_out(cap_a), .cap_b_out(cap_b));

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge mclk);
    reg_addr <= a;
    repeat (2) @(posedge mclk);
    #1 chk({56'h0, reg_rdata}, {56'h0, exp});
  endtask : rd_chk

  // Expected wire pattern of one slot-0 word
  function automatic logic [63:0] ef(int ofs, bit fz, bit on);
    for (int i = 0; i < 64; i++) begin
      ef[i] = fz ? 1'bz : 1'b0;
      if (on && i >= ofs && i < ofs + 16) ef[i] = WORD[31-(i-ofs)];
    end
  endfunction : ef

  task automatic frame(input logic [7:0] line, input logic [7:0] ofs, input logic [7:0] st);
    wr(ADDR_PORT_CFG, 8'h00);
    wr(ADDR_LINE_CFG, line);
    wr(ADDR_OFS_CFG, ofs);
    wr(ADDR_STEER, st);
    i_host.run_frame();
    repeat (2) @(posedge mclk);
  endtask : frame

  task automatic test_regs();
    rd_chk(ADDR_PORT_CFG, PORT_CFG_RST);
    rd_chk(ADDR_LINE_CFG, 8'h00);
    rd_chk(ADDR_OFS_CFG, 8'h00);
    rd_chk(ADDR_STEER, 8'h00);
    wr(ADDR_OFS_CFG, 8'hFF);
    rd_chk(ADDR_OFS_CFG, 8'h1F);
    wr(ADDR_STEER, 8'hA5);
    rd_chk(ADDR_STEER, 8'hA5);
    wr(8'h40, 8'h5A);
    rd_chk(8'h40, 8'h00);
    $display("test_regs done");
  endtask : test_regs

  task automatic test_fill_zero();
    frame(8'h00, 8'h00, 8'h00);
    chk(cap_a, ef(0, 0, 1));
    chk(cap_b, ef(0, 0, 0));
    $display("test_fill_zero done");
  endtask : test_fill_zero

  task automatic test_offset_steer();
    frame(8'h40, 8'h03, 8'h01);
    chk(cap_a, ef(3, 1, 0));
    chk(cap_b, ef(3, 1, 1));
    frame(8'h40, 8'h1F, 8'h00);
    chk(cap_a, ef(31, 1, 1));
    $display("test_offset_steer done");
  endtask : test_offset_steer

  task automatic test_keeper();
    for (int m = 0; m < 2; m++) begin
      wr(ADDR_LINE_CFG, 8'(m << 3));
      repeat (2) @(posedge mclk);
      chk({63'h0, keep}, 64'(m));
    end
    $display("test_keeper done");
  endtask : test_keeper

  // Internal sync pulse width in system clocks
  task automatic test_ctrl(input logic [7:0] line, input int exp);
    int n;
    ctrl_mode <= 1'b1;
    wr(ADDR_LINE_CFG, line);
    // Skip the next pulse, in progress or not, then time the following whole pulse
    for (n = 0; n < 3000 && fs !== 1'b1; n++) @(posedge mclk);
    if (n >= 3000) err_total++;
    for (n = 0; n < 3000 && fs !== 1'b0; n++) @(posedge mclk);
    if (n >= 3000) err_total++;
    for (n = 0; n < 3000 && fs !== 1'b1; n++) @(posedge mclk);
    if (n >= 3000) err_total++;
    for (n = 0; n < 200 && fs === 1'b1; n++) @(posedge mclk);
    chk(64'(n), 64'(exp));
    chk({63'h0, bco}, 64'h0);
    ctrl_mode <= 1'b0;
    $display("test_ctrl done");
  endtask : test_ctrl

  task automatic wrap_up();
    $display("checked=%0d err_total=%0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : wrap_up

  // Main sequence
  initial begin
    srst = 1'b1;
    reg_wr = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    ctrl_mode = 1'b0;
    ch_en = 8'h01;
    ch_slot = '0;
    ch_data = '0;
    ch_data[0] = WORD;
    err_total = 0;
    checked = 0;
    repeat (5) @(posedge mclk);
    srst <= 1'b0;
    test_regs();
    test_fill_zero();
    test_offset_steer();
    test_keeper();
    test_ctrl(8'h07, 2 * 32);
    test_ctrl(8'h06, 32);
    wrap_up();
  end
endmodule : primary_audio_port_transmit_cfg_bench

/* File: bench/psp_host_model.sv */
`timescale 1ns/10ps
module psp_host_model #(
  parameter int HALF = 8
) (
  // System clock
  input  wire logic        mclk_in,
  // Data pins as seen on the wire
  input  wire logic        pin_a_in,
  input  wire logic        pin_b_in,
  // Clocks driven by the host
  output logic             bclk_out,
  output logic             fsync_out,
  // Captured frame, wire bit 0 first
  output logic [63:0]      cap_a_out,
  output logic [63:0]      cap_b_out
);
  // Clocks stand low outside frames
  initial begin
    bclk_out = 1'b0;
    fsync_out = 1'b0;
    cap_a_out = '0;
    cap_b_out = '0;
  end

  // One frame: sync for one period, then 64 bits sampled on rising edges
  task automatic run_frame();
    for (int i = 0; i <= 64; i++) begin
      repeat (HALF) @(posedge mclk_in);
      bclk_out <= 1'b1;
      fsync_out <= (i == 0);
      if (i > 0) begin
        cap_a_out[i-1] <= pin_a_in;
        cap_b_out[i-1] <= pin_b_in;
      end
      repeat (HALF) @(posedge mclk_in);
      bclk_out <= 1'b0;
    end
  endtask : run_frame
endmodule : psp_host_model

/* File: hw/psp_clk_gen.sv */
`timescale 1ns/10ps
module psp_clk_gen
  import psp_pkg::*;
(
  // Clock and reset
  input  wire logic mclk_in,
  input  wire logic srst_in,
  // Control
  input  wire logic run_in,
  input  wire logic tdm_in,
  input  wire logic wide_in,
  // Generated clocks
  output logic      bclk_out,
  output logic      fsync_out
);

  psp_gen_t   q;
  psp_gen_t   n;
  logic [5:0] cnt_n;

  // Divider, frame counter and sync shaping
  always_comb begin
    n     = q;
    cnt_n = q.cnt + 6'h01;
    if (!run_in) begin
      // Park one count before wrap so the first pulse is full width
      n     = GEN_RST;
      n.cnt = 6'h3F;
    end else if (q.div == BCLK_HALF_CYC - 5'h01) begin
      n.div  = 5'h00;
      n.bclk = ~q.bclk;
      if (q.bclk) begin
        n.cnt = cnt_n;
        n.fs  = tdm_in ? (cnt_n < (wide_in ? SYNC_WIDE : SYNC_NARROW))
                       : (cnt_n < FRAME_HALF);
      end
    end else begin
      n.div = q.div + 5'h01;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (srst_in) q <= GEN_RST;
    else         q <= n;
  end

  assign bclk_out  = q.bclk;
  assign fsync_out = q.fs;

  // Sync pulse width checks
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (srst_in);

  sequence s_one_period;
    ##31 fsync_out ##1 !fsync_out;
  endsequence

  sequence s_two_periods;
    ##63 fsync_out ##1 !fsync_out;
  endsequence

  a_sync_narrow: assert property (
    $rose(fsync_out) && run_in && tdm_in && !wide_in |-> s_one_period)
    else $error("narrow sync pulse not one bit period");

  a_sync_wide: assert property (
    $rose(fsync_out) && run_in && tdm_in && wide_in |-> s_two_periods)
    else $error("wide sync pulse not two bit periods");

endmodule : psp_clk_gen

/* File: hw/psp_tx_port.sv */
// Function
// - Launch data on default bit-clock edge, or half cycle later when edge bit set.
// - Unused bit cycles drive zero when fill clear, high-impedance when set.
// - LSB driven full cycle, or first half then released when half bit set.
// - Keeper field: off, always on, one cycle or 1.5 cycles around LSB.
// - In controller mode, internal or external frame sync times data per bit.
// - In controller mode, internal or external bit clock times data per bit.
// - Controller TDM sync pulse is one or two bit-clock periods wide.
// - Five-bit offset delays slot 0 MSB by 0 to 31 bit-clock cycles.
// - Each channel select bit steers channel to first or second data pin.
// - Offset register top three bits reserved, always read zero.
// - Line, offset and steer fields are zero after reset; port slot length resets to 32 bits.
// - Bit-clock polarity bit picks standard or inverted edges; sets default launch.
// - Format field selects TDM, I2S or left-justified; three is reserved.
// - Word-length field selects 16, 20, 24 or 32 bit slots.
`timescale 1ns/10ps
module psp_tx_port
  import psp_pkg::*;
(
  // Clock and reset
  input  wire logic                        mclk_in,
  input  wire logic                        srst_in,
  // Register port
  input  wire logic [7:0]                  reg_addr_in,
  input  wire logic                        reg_wr_in,
  input  wire logic [7:0]                  reg_wdata_in,
  output logic      [7:0]                  reg_rdata_out,
  // Port mode and external clocks
  input  wire logic                        ctrl_mode_in,
  input  wire logic                        ext_bclk_in,
  input  wire logic                        ext_fsync_in,
  output logic                             bclk_out,
  output logic                             bclk_oe_n_out,
  output logic                             fsync_out,
  output logic                             fsync_oe_n_out,
  // Channel sources
  input  wire logic [NCH-1:0][WORD_W-1:0]  ch_data_in,
  input  wire logic [NCH-1:0][4:0]         ch_slot_in,
  input  wire logic [NCH-1:0]              ch_en_in,
  // Serial data pins
  output logic                             serial_out_first_pin_out,
  output logic                             serial_out_first_pin_oe_n_out,
  output logic                             serial_out_second_pin_out,
  output logic                             serial_out_second_pin_oe_n_out,
  output logic                             keeper_en_out
);

  psp_main_t     q;
  psp_main_t     n;
  logic          g_bclk, g_fs, bclk, fs, fsl, rise, fall, any_edge;
  logic          launch, other, out_load, tdm, i2s;
  logic          start_l, start_r, start, wl_end, slot_end, emit, e_lsb, src_l;
  logic [5:0]    lead0, c_lead;
  logic [4:0]    c_bit, c_slot, idx, slot_last;
  logic          c_right;
  psp_fsm_t      c_st;
  logic [NCH-1:0] hit, bv, h0, h1;
  logic [1:0]    e_d, e_v, src_d, src_v, klim;

  // Sequencer step for the running states
  function automatic psp_fsm_t next_st(input psp_fsm_t s, input logic ld1, input logic fend);
    next_st = s;
    case (s)
      ST_IDLE: next_st = ST_IDLE;
      ST_LEAD: if (ld1) next_st = ST_DATA;
      ST_DATA: if (fend) next_st = ST_IDLE;
      default: next_st = ST_IDLE;
    endcase
  endfunction : next_st

  // Internal clock and sync source
  psp_clk_gen u_gen (
    .mclk_in   (mclk_in),
    .srst_in   (srst_in),
    .run_in    (ctrl_mode_in),
    .tdm_in    (tdm),
    .wide_in   (q.line.tdm_sync_pulse_width),
    .bclk_out  (g_bclk),
    .fsync_out (g_fs)
  );

  // Clock and sync selection, edge detection
  assign bclk = (ctrl_mode_in && q.line.tx_use_internal_bit_clock) ? g_bclk : ext_bclk_in;
  assign fs   = (ctrl_mode_in && q.line.tx_use_internal_frame_sync) ? g_fs : ext_fsync_in;
  assign fsl      = fs ^ q.port.fsync_polarity;
  assign rise     = bclk & ~q.bclk_p;
  assign fall     = ~bclk & q.bclk_p;
  assign any_edge = rise | fall;
  assign launch   = q.port.bit_clock_polarity ? rise : fall;
  assign other    = q.port.bit_clock_polarity ? fall : rise;
  assign out_load = q.line.tx_launch_edge_sel ? other : launch;

  // Frame start per format
  assign tdm     = q.port.protocol_format_sel == FMT_TDM;
  assign i2s     = q.port.protocol_format_sel == FMT_I2S;
  assign start_l = i2s ? (~fsl & q.fs_p) : (fsl & ~q.fs_p);
  assign start_r = !tdm && (i2s ? (fsl & ~q.fs_p) : (~fsl & q.fs_p));
  assign start   = start_l | start_r;

  // Position of the bit launched at this edge
  assign lead0     = {1'b0, q.ofs.tx_msb_offset} + (i2s ? 6'h01 : 6'h00);
  assign slot_last = tdm ? SLOT_LAST_TDM : SLOT_LAST_HALF;
  assign wl_end    = q.bitn == WL_LAST[q.port.slot_length_sel];
  assign slot_end  = wl_end && q.slot == slot_last;
  assign c_st      = start ? ((lead0 == 6'h00) ? ST_DATA : ST_LEAD)
                           : next_st(q.st, q.lead == 6'h01, slot_end);
  assign c_lead    = start ? lead0 : ((q.st == ST_LEAD) ? q.lead - 6'h01 : q.lead);
  assign c_bit     = (start || q.st != ST_DATA || wl_end) ? 5'h00 : q.bitn + 5'h01;
  assign c_slot    = start ? 5'h00 : ((q.st == ST_DATA && wl_end) ? q.slot + 5'h01 : q.slot);
  assign c_right   = start ? start_r : q.right;
  assign idx       = tdm ? c_slot : {c_right, c_slot[3:0]};
  assign emit      = c_st == ST_DATA;
  assign e_lsb     = c_bit == WL_LAST[q.port.slot_length_sel];

  // Channel slot match and MSB-first bit pick
  for (genvar c = 0; c < NCH; c++) begin : g_ch
    assign hit[c] = ch_en_in[c] && (ch_slot_in[c] == idx);
    assign bv[c]  = ch_data_in[c][~c_bit];
  end

  // Pin steering
  assign h0  = hit & ~q.steer;
  assign h1  = hit & q.steer;
  assign e_v = {|h1, |h0} & {2{emit}};
  assign e_d = {|(h1 & bv), |(h0 & bv)};

  // Launch source: fresh at default edge, held copy for delayed edge
  assign src_d = q.line.tx_launch_edge_sel ? q.d0 : e_d;
  assign src_v = q.line.tx_launch_edge_sel ? q.v0 : e_v;
  assign src_l = q.line.tx_launch_edge_sel ? q.l0 : e_lsb;
  assign klim  = (q.line.tx_bus_keeper_mode == KEEP_LSB15) ? KEEP_EDGES_ONEHALF : KEEP_EDGES_ONE;

  // Next state
  always_comb begin
    n        = q;
    n.bclk_p = bclk;
    // Register writes
    if (reg_wr_in) begin
      case (reg_addr_in)
        ADDR_PORT_CFG: n.port  = psp_port_cfg_t'(reg_wdata_in);
        ADDR_LINE_CFG: n.line  = psp_line_cfg_t'(reg_wdata_in);
        ADDR_OFS_CFG:  n.ofs   = psp_ofs_cfg_t'(reg_wdata_in & OFS_WR_MASK);
        ADDR_STEER:    n.steer = reg_wdata_in;
        default:       n.steer = q.steer;
      endcase
    end
    // Register reads, unmapped read zero
    case (reg_addr_in)
      ADDR_PORT_CFG: n.rdata = q.port;
      ADDR_LINE_CFG: n.rdata = q.line;
      ADDR_OFS_CFG:  n.rdata = q.ofs;
      ADDR_STEER:    n.rdata = q.steer;
      default:       n.rdata = 8'h00;
    endcase
    // Frame sequencing on the default edge
    if (launch) begin
      n.fs_p  = fsl;
      n.st    = c_st;
      n.lead  = c_lead;
      n.bitn  = c_bit;
      n.slot  = c_slot;
      n.right = c_right;
      n.d0    = e_d & e_v;
      n.v0    = e_v;
      n.l0    = e_lsb;
    end
    // Keeper window and LSB half-cycle release
    if (q.kact && any_edge) begin
      n.kc = q.kc + 2'h1;
      if (q.kc + 2'h1 == klim) n.kact = 1'b0;
      if (q.kc == 2'h0 && q.line.tx_lsb_half_cycle) n.drv = q.drv & ~q.lv;
    end
    // Pin update at the launch edge
    if (out_load) begin
      n.dat = src_d & src_v;
      n.drv = src_v | {2{~q.line.tx_unused_fill_sel}};
      n.lv  = src_v & {2{src_l}};
      if (src_l && |src_v) begin
        n.kact = 1'b1;
        n.kc   = 2'h0;
      end
    end
  end

  always_ff @(posedge mclk_in) begin
    if (srst_in) q <= MAIN_RST;
    else         q <= n;
  end

  // Outputs
  assign reg_rdata_out                  = q.rdata;
  assign bclk_out                       = g_bclk;
  assign fsync_out                      = g_fs;
  assign bclk_oe_n_out                  = ~ctrl_mode_in;
  assign fsync_oe_n_out                 = ~ctrl_mode_in;
  assign serial_out_first_pin_out       = q.dat[0];
  assign serial_out_first_pin_oe_n_out  = ~q.drv[0];
  assign serial_out_second_pin_out      = q.dat[1];
  assign serial_out_second_pin_oe_n_out = ~q.drv[1];
  assign keeper_en_out = (q.line.tx_bus_keeper_mode == KEEP_ON) ||
                         (q.line.tx_bus_keeper_mode[1] && q.kact);

  // Checks
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (srst_in);

  a_reset_clear: assert property (disable iff (1'b0)
    srst_in |=> q.line == LINE_CFG_RST && q.ofs == OFS_CFG_RST && q.steer == STEER_RST)
    else $error("config not zero after reset");

  a_ofs_reserved: assert property (
    reg_wr_in && reg_addr_in == ADDR_OFS_CFG |=> ##1 reg_addr_in != ADDR_OFS_CFG
    || reg_rdata_out[7:5] == 3'h0)
    else $error("offset reserved bits not zero");

  a_edge_delayed: assert property (
    q.line.tx_launch_edge_sel && other && !srst_in |=> q.dat == $past(q.d0))
    else $error("delayed launch did not use held bit");

  a_fill_zero: assert property (
    out_load && !src_v[0] && !q.line.tx_unused_fill_sel |=> q.drv[0] && !q.dat[0])
    else $error("unused cycle not driven zero");

  a_fill_hiz: assert property (
    out_load && !src_v[1] && q.line.tx_unused_fill_sel |=> !q.drv[1])
    else $error("unused cycle not released");

  a_lsb_half: assert property (
    q.kact && q.kc == 2'h0 && any_edge && q.lv[0] && q.line.tx_lsb_half_cycle
    && !out_load |=> !q.drv[0])
    else $error("LSB not released after half cycle");

  a_lsb_full: assert property (
    q.kact && q.kc == 2'h0 && any_edge && q.lv[0] && !q.line.tx_lsb_half_cycle
    && !reg_wr_in |=> q.drv[0])
    else $error("LSB released early");

  a_keeper_off: assert property (
    q.line.tx_bus_keeper_mode == KEEP_OFF |-> !keeper_en_out)
    else $error("keeper on while disabled");

  a_keeper_one: assert property (
    q.line.tx_bus_keeper_mode == KEEP_LSB1 && q.kc == 2'h1 && any_edge && !out_load
    && !reg_wr_in |=> !keeper_en_out)
    else $error("keeper window longer than one cycle");

  a_int_bclk: assert property (
    ctrl_mode_in && q.line.tx_use_internal_bit_clock && !reg_wr_in |=> q.bclk_p == $past(g_bclk))
    else $error("internal bit clock not used");

  a_offset_lead: assert property (
    launch && start |=> q.lead == $past(lead0) && (q.st == ST_LEAD) == ($past(lead0) != 6'h00))
    else $error("slot 0 offset not applied");

  a_steer_pin: assert property (
    launch && emit && |h1 && !reg_wr_in |=> q.v0[1])
    else $error("steered channel missing on second pin");

endmodule : psp_tx_port

/* File: include/psp_pkg.sv */
package psp_pkg;

  // Register map
  localparam logic [7:0] ADDR_PORT_CFG = 8'h1A;
  localparam logic [7:0] ADDR_LINE_CFG = 8'h1B;
  localparam logic [7:0] ADDR_OFS_CFG  = 8'h1C;
  localparam logic [7:0] ADDR_STEER    = 8'h1D;

  // Reset values and write masks
  localparam logic [7:0] PORT_CFG_RST = 8'h30;
  localparam logic [7:0] LINE_CFG_RST = 8'h00;
  localparam logic [7:0] OFS_CFG_RST  = 8'h00;
  localparam logic [7:0] STEER_RST    = 8'h00;
  localparam logic [7:0] OFS_WR_MASK  = 8'h1F;

  // Port geometry
  localparam int NCH    = 8;
  localparam int WORD_W = 32;

  // Internal bit clock timing
  localparam int         MCLK_HZ       = 100_000_000;
  localparam int         BCLK_HZ       = 3_125_000;
  localparam logic [4:0] BCLK_HALF_CYC = 5'(MCLK_HZ / (2 * BCLK_HZ));
  localparam logic [5:0] FRAME_HALF    = 6'h20;
  localparam logic [5:0] SYNC_NARROW   = 6'h01;
  localparam logic [5:0] SYNC_WIDE     = 6'h02;

  // Keeper window lengths in bit-clock edges
  localparam logic [1:0] KEEP_EDGES_ONE     = 2'h2;
  localparam logic [1:0] KEEP_EDGES_ONEHALF = 2'h3;

  // Slot and word limits
  localparam logic [4:0] SLOT_LAST_TDM  = 5'h1F;
  localparam logic [4:0] SLOT_LAST_HALF = 5'h0F;
  localparam logic [4:0] WL_LAST [0:3]  = '{5'h0F, 5'h13, 5'h17, 5'h1F};

  // Protocol formats
  typedef enum logic [1:0] {
    FMT_TDM  = 2'h0,
    FMT_I2S  = 2'h1,
    FMT_LJ   = 2'h2,
    FMT_RSVD = 2'h3
  } psp_fmt_t;

  // Bus keeper modes
  typedef enum logic [1:0] {
    KEEP_OFF   = 2'h0,
    KEEP_ON    = 2'h1,
    KEEP_LSB1  = 2'h2,
    KEEP_LSB15 = 2'h3
  } psp_keep_t;

  // Frame sequencer states
  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_LEAD = 3'h2,
    ST_DATA = 3'h4
  } psp_fsm_t;

  // Port configuration register fields
  typedef struct packed {
    logic [1:0] protocol_format_sel;
    logic [1:0] slot_length_sel;
    logic       fsync_polarity;
    logic       bit_clock_polarity;
    logic       bus_err_dis;
    logic       bus_err_resume_dis;
  } psp_port_cfg_t;

  // Line behaviour register fields
  typedef struct packed {
    logic       tx_launch_edge_sel;
    logic       tx_unused_fill_sel;
    logic       tx_lsb_half_cycle;
    logic [1:0] tx_bus_keeper_mode;
    logic       tx_use_internal_frame_sync;
    logic       tx_use_internal_bit_clock;
    logic       tdm_sync_pulse_width;
  } psp_line_cfg_t;

  // Offset register fields
  typedef struct packed {
    logic [2:0] rsvd;
    logic [4:0] tx_msb_offset;
  } psp_ofs_cfg_t;

  // Transmit block state
  typedef struct packed {
    psp_port_cfg_t port;
    psp_line_cfg_t line;
    psp_ofs_cfg_t  ofs;
    logic [7:0]    steer;
    logic [7:0]    rdata;
    logic          bclk_p;
    logic          fs_p;
    psp_fsm_t      st;
    logic [5:0]    lead;
    logic [4:0]    bitn;
    logic [4:0]    slot;
    logic          right;
    logic [1:0]    d0;
    logic [1:0]    v0;
    logic          l0;
    logic [1:0]    dat;
    logic [1:0]    drv;
    logic [1:0]    lv;
    logic          kact;
    logic [1:0]    kc;
  } psp_main_t;

  // Clock generator state
  typedef struct packed {
    logic [4:0] div;
    logic [5:0] cnt;
    logic       bclk;
    logic       fs;
  } psp_gen_t;

  localparam psp_main_t MAIN_RST = '{port: psp_port_cfg_t'(PORT_CFG_RST),
                                     line: psp_line_cfg_t'(LINE_CFG_RST),
                                     ofs: psp_ofs_cfg_t'(OFS_CFG_RST),
                                     steer: STEER_RST, st: ST_IDLE, default: '0};
  localparam psp_gen_t  GEN_RST  = '{default: '0};

endpackage : psp_pkg
